/* hdl/oag_top.v */
// Operand address generator of the 8-bit core
// Summary of operation
// RULE1: Register mode returns A, X, Y, carry or status word; no address.
// RULE2: Immediate mode returns the operand byte as the value.
// RULE3: Flag set: page access address is page register high, operand low.
// RULE4: Direct page mode uses the operand byte as offset in the page.
// RULE5: Absolute mode: second byte low, third byte high, full space.
// RULE6: X-indexed mode uses X as the offset in the direct page.
// RULE7: Auto-increment addresses through X then adds one to X.
// RULE8: Operand plus X, wrapped inside the direct page.
// RULE9: Operand plus Y, wrapped inside the direct page.
// RULE10: Absolute operand plus Y reaches the full address space.
// RULE11: Direct page indirect jump reads a byte pair as target.
// RULE12: Operand plus X locates a pointer pair; access its target.
// RULE13: Pointer pair at operand, plus Y, gives the data address.
// RULE14: Absolute indirect jump targets the pointer at the absolute operand.
// RULE15: Flag clear selects page zero whatever the page register holds.
// RULE16: Software sets the flag after writing the page register.
// RULE17: A fetched pointer takes low byte first, high byte next.
//
// Local design decision: the strobed register port.
`include "oag_consts.vh"
module oag_top (
  input wire clk_i,
  input wire rst_n_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // Sequencer request
  input wire req_i,
  input wire [3:0] mode_i,
  input wire [2:0] reg_sel_i,
  input wire [7:0] op1_i,
  input wire [7:0] op2_i,
  input wire jump_i,
  input wire set_page_flag_instr_i,
  input wire clear_page_flag_instr_i,
  input wire [7:0] acc_i,
  input wire [7:0] x_i,
  input wire [7:0] y_i,
  input wire carry_i,
  input wire [7:0] program_status_word_i,
  // Memory pointer read
  output reg mem_rd_o,
  output reg [15:0] mem_addr_o,
  input wire [7:0] mem_rdata_i,
  // Results
  output reg done_o,
  output reg is_value_o,
  output reg [7:0] value_o,
  output reg [15:0] ea_o,
  output reg jump_o,
  output reg x_wr_o,
  output reg [7:0] x_nxt_o,
  output reg page_flag_o
);
  // ==========================================
  // Reset release
  // ==========================================
  reg [1:0] rst_sync_r;
  wire rst_n;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ==========================================
  // Page register
  // ==========================================
  wire page_wr;
  wire [2:0] page_sel;
  wire [2:0] page_eff;
  wire page_flag;
  assign page_wr = reg_wr_i && (reg_addr_i == `OAG_ADDR_PAGE_SEL);
  oag_page_reg u_page (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .wr_i(page_wr),
    .wdata_i(reg_wdata_i[2:0]),
    .set_flag_i(set_page_flag_instr_i),
    .clr_flag_i(clear_page_flag_instr_i),
    .page_sel_o(page_sel),
    .page_eff_o(page_eff),
    .flag_o(page_flag)
  );

  // Upper byte of every direct page address
  wire [7:0] dp_high;
  assign dp_high = page_flag ? {5'b00000, page_eff} : 8'h00; // [RULE3] [RULE15]

  // ==========================================
  // Register read port
  // ==========================================
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
      page_flag_o <= 1'b0;
    end else begin
      page_flag_o <= page_flag;
      if (reg_rd_i && reg_addr_i == `OAG_ADDR_PAGE_SEL) begin
        reg_rdata_o <= {5'b00000, page_sel};
      end else begin
        // Unmapped addresses read zero
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================
  // Direct address forming
  // ==========================================
  wire [7:0] dpx_off;
  wire [7:0] dpy_off;
  wire [15:0] abs_addr;
  wire [15:0] absy_addr;
  assign dpx_off = op1_i + x_i; // [RULE8] [RULE12]
  assign dpy_off = op1_i + y_i; // [RULE9]
  assign abs_addr = {op2_i, op1_i}; // [RULE5] [RULE14]
  assign absy_addr = abs_addr + {8'h00, y_i}; // [RULE10]

  // Pointer base for indirect modes
  reg [15:0] ptr_base;
  always @* begin
    case (mode_i)
      `OAG_M_INDX: ptr_base = {dp_high, dpx_off}; // [RULE12]
      `OAG_M_ABSIND: ptr_base = abs_addr; // [RULE14]
      default: ptr_base = {dp_high, op1_i}; // [RULE11] [RULE13]
    endcase
  end

  wire indirect;
  assign indirect = (mode_i == `OAG_M_IND) || (mode_i == `OAG_M_INDX) ||
    (mode_i == `OAG_M_INDY) || (mode_i == `OAG_M_ABSIND);

  // ==========================================
  // Pointer fetch
  // ==========================================
  wire fetch_busy;
  wire fetch_done;
  wire [15:0] fetch_addr;
  wire [15:0] fetch_ptr;
  wire fetch_start;
  reg [3:0] mode_r;
  reg [7:0] y_r;
  reg jump_r;
  // High while the low byte is on the bus; the high byte address follows
  reg fetch_lo_r;
  assign fetch_start = req_i && indirect && !fetch_busy;
  oag_ptr_fetch u_fetch (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .start_i(fetch_start),
    .base_i(ptr_base),
    .rdata_i(mem_rdata_i),
    .busy_o(fetch_busy),
    .addr_o(fetch_addr),
    .done_o(fetch_done),
    .ptr_o(fetch_ptr)
  );

  // ==========================================
  // Result registers
  // ==========================================
  reg [7:0] reg_val;
  always @* begin
    case (reg_sel_i)
      `OAG_R_ACC: reg_val = acc_i; // [RULE1]
      `OAG_R_X: reg_val = x_i; // [RULE1]
      `OAG_R_Y: reg_val = y_i; // [RULE1]
      `OAG_R_C: reg_val = {7'h00, carry_i}; // [RULE1]
      `OAG_R_PSW: reg_val = program_status_word_i; // [RULE1]
      default: reg_val = 8'h00;
    endcase
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      done_o <= 1'b0;
      is_value_o <= 1'b0;
      value_o <= 8'h00;
      ea_o <= 16'h0000;
      jump_o <= 1'b0;
      x_wr_o <= 1'b0;
      x_nxt_o <= 8'h00;
      mem_rd_o <= 1'b0;
      mem_addr_o <= 16'h0000;
      mode_r <= `OAG_M_REG;
      y_r <= 8'h00;
      jump_r <= 1'b0;
      fetch_lo_r <= 1'b0;
    end else begin
      done_o <= 1'b0;
      x_wr_o <= 1'b0;
      // Two reads per pointer, so the memory sees each address for a cycle
      mem_rd_o <= fetch_start || fetch_lo_r; // [RULE17]
      fetch_lo_r <= fetch_start;
      if (fetch_start) begin
        mode_r <= mode_i;
        y_r <= y_i;
        jump_r <= jump_i;
      end
      if (fetch_start) begin
        mem_addr_o <= ptr_base;
      end else if (fetch_lo_r) begin
        // Present the high byte address before the fetcher samples it
        mem_addr_o <= fetch_addr; // [RULE17]
      end
      if (fetch_done) begin
        done_o <= 1'b1;
        is_value_o <= 1'b0;
        jump_o <= jump_r; // [RULE11] [RULE14]
        if (mode_r == `OAG_M_INDY) begin
          ea_o <= fetch_ptr + {8'h00, y_r}; // [RULE13]
        end else begin
          ea_o <= fetch_ptr; // [RULE11] [RULE12]
        end
      end else if (req_i && !indirect && !fetch_busy) begin
        done_o <= 1'b1;
        jump_o <= jump_i;
        is_value_o <= 1'b0;
        case (mode_i)
          `OAG_M_REG: begin
            is_value_o <= 1'b1;
            value_o <= reg_val; // [RULE1]
          end
          `OAG_M_IMM: begin
            is_value_o <= 1'b1;
            value_o <= op1_i; // [RULE2]
          end
          `OAG_M_DP: ea_o <= {dp_high, op1_i}; // [RULE4] [RULE3]
          `OAG_M_ABS: ea_o <= abs_addr; // [RULE5]
          `OAG_M_X: ea_o <= {dp_high, x_i}; // [RULE6]
          `OAG_M_XINC: begin
            ea_o <= {dp_high, x_i}; // [RULE7]
            x_wr_o <= 1'b1;
            x_nxt_o <= x_i + 8'h01; // [RULE7]
          end
          `OAG_M_DPX: ea_o <= {dp_high, dpx_off}; // [RULE8]
          `OAG_M_DPY: ea_o <= {dp_high, dpy_off}; // [RULE9]
          `OAG_M_ABSY: ea_o <= absy_addr; // [RULE10]
          default: ea_o <= 16'h0000;
        endcase
      end
    end
  end
endmodule // oag_top

/* hdl/oag_consts.vh */
// Constants of the operand address generator
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
// Register map
`define OAG_ADDR_PAGE_SEL 8'hE1
`define OAG_PAGE_SEL_W 3
`define OAG_PAGE_SEL_RST 3'h0
// Addressing mode codes
`define OAG_M_REG 4'h0
`define OAG_M_IMM 4'h1
`define OAG_M_DP 4'h2
`define OAG_M_ABS 4'h3
`define OAG_M_X 4'h4
`define OAG_M_XINC 4'h5
`define OAG_M_DPX 4'h6
`define OAG_M_DPY 4'h7
`define OAG_M_ABSY 4'h8
`define OAG_M_IND 4'h9
`define OAG_M_INDX 4'hA
`define OAG_M_INDY 4'hB
`define OAG_M_ABSIND 4'hC
// Register operand select
`define OAG_R_ACC 3'h0
`define OAG_R_X 3'h1
`define OAG_R_Y 3'h2
`define OAG_R_C 3'h3
`define OAG_R_PSW 3'h4
`endif

/* hdl/oag_page_reg.v */
// RAM page select register and page flag
`include "oag_consts.vh"
module oag_page_reg (
  input wire clk_i,
  input wire rst_n_i,
  input wire wr_i,
  input wire [2:0] wdata_i,
  input wire set_flag_i,
  input wire clr_flag_i,
  output reg [2:0] page_sel_o,
  output reg [2:0] page_eff_o,
  output reg flag_o
);
  // ==========================================
  // Page state
  // ==========================================
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      page_sel_o <= `OAG_PAGE_SEL_RST;
      page_eff_o <= `OAG_PAGE_SEL_RST;
      flag_o <= 1'b0;
    end else begin
      if (wr_i) begin
        page_sel_o <= wdata_i;
      end
      // New page only takes effect at the set-flag instruction [RULE16]
      if (set_flag_i) begin
        flag_o <= 1'b1;
        page_eff_o <= wr_i ? wdata_i : page_sel_o;
      end else if (clr_flag_i) begin
        flag_o <= 1'b0;
      end
    end
  end
endmodule // oag_page_reg

/* hdl/oag_ptr_fetch.v */
// Pointer assembly from two byte reads of a direct page or absolute pair
module oag_ptr_fetch (
  input wire clk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [15:0] base_i,
  input wire [7:0] rdata_i,
  output wire busy_o,
  output wire [15:0] addr_o,
  output reg done_o,
  output reg [15:0] ptr_o
);
  // ==========================================
  // Two-byte sequencer
  // ==========================================
  localparam ST_IDLE = 2'd0;
  localparam ST_LO = 2'd1;
  localparam ST_HI = 2'd2;
  reg [1:0] st_r;
  reg [15:0] base_r;
  reg [7:0] lo_r;
  assign busy_o = (st_r != ST_IDLE);
  // Address of the next byte to read: high byte at the next location,
  // wrapping inside the page
  assign addr_o = (st_r == ST_LO) ?
    {base_r[15:8], base_r[7:0] + 8'h01} : base_r;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      base_r <= 16'h0000;
      lo_r <= 8'h00;
      done_o <= 1'b0;
      ptr_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (start_i) begin
            base_r <= base_i;
            st_r <= ST_LO;
          end
        end
        ST_LO: begin
          lo_r <= rdata_i; // [RULE17]
          st_r <= ST_HI;
        end
        ST_HI: begin
          ptr_o <= {rdata_i, lo_r}; // [RULE17]
          done_o <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // oag_ptr_fetch

/* test/oag_mem_model.sv */
// Program and data memory model answering pointer reads
module oag_mem_model (
  input wire logic [15:0] addr_i,
  output wire logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Combinational read; content is a fixed function of the address
  assign data_o = addr_i[7:0] + 8'h03 * addr_i[15:8] + 8'h11;
endmodule // oag_mem_model

/* test/oag_top_assertions.sv */
// Concurrent checks on the operand address generator ports
`include "oag_consts.vh"
module oag_top_assertions (
  input wire clk_i,
  input wire rst_n_i,
  input wire req_i,
  input wire [3:0] mode_i,
  input wire [2:0] reg_sel_i,
  input wire [7:0] op1_i,
  input wire [7:0] op2_i,
  input wire [7:0] acc_i,
  input wire [7:0] x_i,
  input wire [7:0] y_i,
  input wire page_flag_o,
  input wire mem_rd_o,
  input wire done_o,
  input wire is_value_o,
  input wire [7:0] value_o,
  input wire [15:0] ea_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend_r;
  logic ind;
  logic go;
  assign ind = mode_i >= `OAG_M_IND;
  // Requests during an open pointer fetch are dropped, so ignore them
  assign go = req_i && !pend_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_r <= 1'b0;
    end else if (go && ind) begin
      pend_r <= 1'b1;
    end else if (done_o) begin
      pend_r <= 1'b0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Checks
  reg_acc_a: assert property (
    go && mode_i == `OAG_M_REG && reg_sel_i == `OAG_R_ACC
    |=> is_value_o && value_o == $past(acc_i)) else $error("acc bad");
  imm_value_a: assert property (
    go && mode_i == `OAG_M_IMM
    |=> done_o && is_value_o && value_o == $past(op1_i)) else $error("imm");
  abs_addr_a: assert property (
    go && mode_i == `OAG_M_ABS
    |=> ea_o == {$past(op2_i), $past(op1_i)}) else $error("abs bad");
  page_zero_a: assert property (
    go && mode_i == `OAG_M_DP && !page_flag_o
    |=> ea_o == {8'h00, $past(op1_i)}) else $error("page zero bad");
  dpx_wrap_a: assert property (
    go && mode_i == `OAG_M_DPX && !page_flag_o
    |=> ea_o == {8'h00, $past(op1_i) + $past(x_i)}) else $error("dpx");
  dpy_wrap_a: assert property (
    go && mode_i == `OAG_M_DPY && !page_flag_o
    |=> ea_o == {8'h00, $past(op1_i) + $past(y_i)}) else $error("dpy");
  absy_sum_a: assert property (
    go && mode_i == `OAG_M_ABSY
    |=> ea_o == {$past(op2_i), $past(op1_i)} + $past(y_i)) else $error("absy");
  ind_done_a: assert property (
    go && ind |=> ##1 !done_o[*2] ##1 done_o) else $error("ind late");
  ind_reads_a: assert property (
    go && ind |=> mem_rd_o ##1 mem_rd_o ##1 !mem_rd_o)
    else $error("pointer reads bad");
  cover property (go && ind);
  cover property (go && mode_i == `OAG_M_XINC);
  cover property (done_o && page_flag_o);
endmodule // oag_top_assertions

/* test/oag_top_tb.sv */
// Self-checking bench of the operand address generator
`include "oag_consts.vh"
module oag_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic v; logic j; logic [7:0] d; logic [15:0] a;}
    oag_exp_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, req_i = 1'b0, jump_i = 1'b0;
  logic set_page_flag_instr_i = 1'b0, clear_page_flag_instr_i = 1'b0;
  logic carry_i = 1'b0, rd_d = 1'b0, flag = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, op1_i = 8'h00;
  logic [7:0] op2_i = 8'h00, acc_i = 8'h00, x_i = 8'h00, y_i = 8'h00;
  logic [7:0] program_status_word_i = 8'h00;
  logic [3:0] mode_i = 4'h0;
  logic [2:0] reg_sel_i = 3'h0, pw = 3'h0, pe = 3'h0;
  logic mem_rd_o, done_o, is_value_o, jump_o, x_wr_o, page_flag_o;
  logic [7:0] reg_rdata_o, mem_rdata_i, value_o, x_nxt_o;
  logic [15:0] mem_addr_o, ea_o;
  oag_exp_t eq[$];
  oag_exp_t me;
  logic [7:0] rq[$];
  logic [7:0] xq[$];
  int bad_count = 0, checks_done = 0, seed = 30;
  initial forever #5 clk_i = ~clk_i;
  oag_top DUT (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .req_i, .mode_i, .reg_sel_i, .op1_i, .op2_i,
    .jump_i, .set_page_flag_instr_i, .clear_page_flag_instr_i, .acc_i, .x_i,
    .y_i, .carry_i, .program_status_word_i, .mem_rd_o, .mem_addr_o,
    .mem_rdata_i, .done_o, .is_value_o, .value_o, .ea_o, .jump_o, .x_wr_o,
    .x_nxt_o, .page_flag_o);
  oag_mem_model mem_u (.addr_i(mem_addr_o), .data_o(mem_rdata_i));
  // ==========================================
  // Tasks
  task automatic chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (e !== s) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tick(input logic w, r, q, s, c);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= r;
    req_i <= q;
    set_page_flag_instr_i <= s;
    clear_page_flag_instr_i <= c;
  endtask
  task automatic wr(input logic [7:0] a, d);
    tick(1, 0, 0, 0, 0);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    pw = d[2:0];
  endtask
  task automatic rd(input logic [7:0] a, e);
    tick(0, 1, 0, 0, 0);
    reg_addr_i <= a;
    rq.push_back(e);
  endtask
  task automatic flg(input logic s);
    tick(0, 0, 0, s, !s);
    flag = s;
    if (s) pe = pw;
    tick(0, 0, 0, 0, 0);
    tick(0, 0, 0, 0, 0);
    tick(0, 0, 0, 0, 0);
    chk("flag", s, page_flag_o);
  endtask
  task automatic go(input logic [3:0] m, input logic [2:0] s);
    logic [7:0] hi, o1, o2, av, xv, yv, pv;
    logic [7:0] rv [0:4];
    logic [15:0] b, p, ea;
    logic cv;
    oag_exp_t ex;
    {o1, o2, av, xv} = $random(seed);
    {yv, pv, cv} = 17'($random(seed));
    rv = '{av, xv, yv, {7'h00, cv}, pv};
    hi = flag ? {5'h00, pe} : 8'h00;
    b = {hi, (m == `OAG_M_INDX) ? o1 + xv : o1};
    if (m == `OAG_M_ABSIND) b = {o2, o1};
    p = {mb({b[15:8], b[7:0] + 8'h01}), mb(b)};
    case (m)
      `OAG_M_DP: ea = {hi, o1};
      `OAG_M_ABS: ea = {o2, o1};
      `OAG_M_X, `OAG_M_XINC: ea = {hi, xv};
      `OAG_M_DPX: ea = {hi, o1 + xv};
      `OAG_M_DPY: ea = {hi, o1 + yv};
      `OAG_M_ABSY: ea = {o2, o1} + yv;
      `OAG_M_INDY: ea = p + yv;
      default: ea = p;
    endcase
    ex.v = m <= `OAG_M_IMM;
    ex.j = m == `OAG_M_IND || m == `OAG_M_ABSIND;
    ex.d = (m == `OAG_M_IMM) ? o1 : rv[s];
    ex.a = ea;
    tick(0, 0, 1, 0, 0);
    {op1_i, op2_i, acc_i, x_i, y_i} <= {o1, o2, av, xv, yv};
    {program_status_word_i, carry_i, jump_i} <= {pv, cv, ex.j};
    {mode_i, reg_sel_i} <= {m, s};
    eq.push_back(ex);
    if (m == `OAG_M_XINC) xq.push_back(xv + 8'h01);
    if (m >= `OAG_M_IND) begin
      // Second request lands while the fetch is busy and must vanish
      tick(0, 0, 1, 0, 0);
      tick(0, 0, 0, 0, 0);
      for (int i = 0; i < 20 && eq.size() > 0; i++) @(posedge clk_i);
      if (eq.size() > 0) begin
        bad_count++;
        conclude();
      end
    end
  endtask
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] + 8'h03 * a[15:8] + 8'h11;
  endfunction
  // ==========================================
  // Result monitor
  always @(posedge clk_i) begin
    rd_d <= reg_rd_i;
    if (rd_d) chk("rdata", rq.pop_front(), reg_rdata_o);
    if (x_wr_o) chk("x next", xq.pop_front(), x_nxt_o);
    if (done_o && eq.size() == 0) chk("extra done", 0, 1);
    else if (done_o) begin
      me = eq.pop_front();
      chk("kind", me.v, is_value_o);
      chk("jump", me.j, jump_o);
      if (me.v) chk("value", me.d, value_o);
      else chk("ea", me.a, ea_o);
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(`OAG_ADDR_PAGE_SEL, 8'h00);
    wr(`OAG_ADDR_PAGE_SEL, 8'hFD);
    rd(`OAG_ADDR_PAGE_SEL, 8'h05);
    rd(8'h40, 8'h00);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) flg(1'b1);
      for (int m = 0; m <= 12; m++)
        for (int s = 0; s < 5; s++)
          if (s == 0 || m == 0) go(4'(m), 3'(s));
      $display("mode sweep %0d done", k);
    end
    // Page write without a set-flag pulse keeps the old page
    wr(`OAG_ADDR_PAGE_SEL, 8'h02);
    go(`OAG_M_DP, 3'h0);
    flg(1'b0);
    go(`OAG_M_DP, 3'h0);
    repeat (4) tick(0, 0, 0, 0, 0);
    chk("x pending", 0, xq.size());
    $display("page switch test done");
    conclude();
  end
endmodule // oag_top_tb
bind oag_top oag_top_assertions chk_u (.clk_i, .rst_n_i, .req_i, .mode_i,
  .reg_sel_i, .op1_i, .op2_i, .acc_i, .x_i, .y_i, .page_flag_o, .mem_rd_o,
  .done_o,
  .is_value_o, .value_o, .ea_o);
